// file: src/nvm_pkg.sv
// constants, field positions and types shared by the nonvolatile controller
package nvm_pkg;

	// ==================================================
	// register offsets
	localparam logic [3:0] OFS_COMMAND = 4'h0;
	localparam logic [3:0] OFS_LOCK = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h3;
	localparam logic [3:0] OFS_IRQ_FLAG = 4'h4;
	localparam logic [3:0] OFS_FUSE_LO = 4'h6;
	localparam logic [3:0] OFS_FUSE_HI = 4'h7;
	localparam logic [3:0] OFS_ADDR_LO = 4'h8;
	localparam logic [3:0] OFS_ADDR_HI = 4'h9;

	// ==================================================
	// field positions
	localparam int CMD_LSB = 0;
	localparam int CMD_MSB = 2;
	localparam int LOCK_APP_BIT = 0;
	localparam int LOCK_BOOT_BIT = 1;
	localparam int STAT_FLASH_BIT = 0;
	localparam int STAT_EEPROM_BIT = 1;
	localparam int STAT_FAULT_BIT = 2;
	localparam int IRQ_READY_BIT = 0;

	// ==================================================
	// reset values and vector
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] READY_VECTOR_OFS = 8'h00;

	// ==================================================
	// memory map regions, plain defaults
	localparam logic [15:0] BOOT_LAST_DEF = 16'h01FF;
	localparam logic [15:0] APP_LAST_DEF = 16'h0FFF;
	localparam logic [15:0] EE_FIRST_DEF = 16'h1400;
	localparam logic [15:0] EE_LAST_DEF = 16'h147F;

	// ==================================================
	// types
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_PAGE_PROGRAM = 3'h1,
		CMD_PAGE_WIPE = 3'h2,
		CMD_WIPE_THEN_PROGRAM = 3'h3,
		CMD_BUFFER_RESET = 3'h4,
		CMD_WHOLE_CHIP_WIPE = 3'h5,
		CMD_EEPROM_WIPE = 3'h6,
		CMD_FUSE_PROGRAM = 3'h7
	} cmd_t;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'h0,
		MODE_STANDBY = 2'h1,
		MODE_POWER_DOWN = 2'h2
	} sleep_mode_t;

	typedef enum logic [1:0] {
		SLP_RUN = 2'h0,
		SLP_HOLD = 2'h1,
		SLP_ASLEEP = 2'h3,
		SLP_WAKE = 2'h2
	} sleep_state_t;

endpackage

// file: src/nvm_busy_if.sv
// busy and ready signals between the busy tracker and the controller
`timescale 1ns/100ps
interface nvm_busy_if;
	logic flash_busy;
	logic eeprom_busy;
	logic ready_pulse;
	logic write_active;

	modport tracker (
		output flash_busy,
		output eeprom_busy,
		output ready_pulse,
		output write_active
	);
	modport ctrl (
		input flash_busy,
		input eeprom_busy,
		input ready_pulse,
		input write_active
	);
endinterface

// file: src/nvm_busy_tracker.sv
// registers array busy levels and marks the end of an eeprom command
`timescale 1ns/100ps
module nvm_busy_tracker (
	input wire logic mclk,
	input wire logic srst,
	input wire logic flash_busy_in,
	input wire logic eeprom_busy_in,
	nvm_busy_if.tracker bus
);
	import nvm_pkg::*;

	typedef struct packed {
		logic flash_busy;
		logic eeprom_busy;
		logic ready_pulse;
	} trk_state_t;

	trk_state_t s_reg;
	trk_state_t s_next;

	// ==================================================
	// state update
	always_comb
	begin
		s_next = s_reg;
		s_next.flash_busy = flash_busy_in;
		s_next.eeprom_busy = eeprom_busy_in;
		s_next.ready_pulse = s_reg.eeprom_busy & ~eeprom_busy_in;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign bus.flash_busy = s_reg.flash_busy;
	assign bus.eeprom_busy = s_reg.eeprom_busy;
	assign bus.ready_pulse = s_reg.ready_pulse;
	assign bus.write_active = s_reg.flash_busy | s_reg.eeprom_busy;

	// ==================================================
	// checks
	sequence s_ee_fall;
		eeprom_busy_in ##1 !eeprom_busy_in;
	endsequence

	property p_ready_on_fall;
		@(posedge mclk) disable iff (srst)
		s_ee_fall |=> bus.ready_pulse;
	endproperty
	a_ready_on_fall: assert property (p_ready_on_fall) else $error("no ready pulse");

	property p_busy_follows;
		@(posedge mclk) disable iff (srst)
		1 |=> (bus.eeprom_busy == $past(eeprom_busy_in)) && (bus.flash_busy == $past(flash_busy_in));
	endproperty
	a_busy_follows: assert property (p_busy_follows) else $error("busy status stale");
endmodule

// file: src/nvm_command_controller.sv
// register file, command issue, locks, interrupt and sleep handling
`timescale 1ns/100ps
module nvm_command_controller #(
	parameter logic [15:0] BOOT_LAST = nvm_pkg::BOOT_LAST_DEF,
	parameter logic [15:0] APP_LAST = nvm_pkg::APP_LAST_DEF,
	parameter logic [15:0] EE_FIRST = nvm_pkg::EE_FIRST_DEF,
	parameter logic [15:0] EE_LAST = nvm_pkg::EE_LAST_DEF
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic self_program_key_window,
	input wire logic access_from_debug,
	input wire logic exec_in_boot,
	input wire logic buf_store,
	input wire logic [15:0] buf_store_addr,
	input wire logic buf_mixed_sections,
	input wire logic keep_eeprom_on_wipe,
	input wire logic flash_busy_in,
	input wire logic eeprom_busy_in,
	input wire logic sleep_req,
	input wire nvm_pkg::sleep_mode_t sleep_mode,
	output logic op_start,
	output nvm_pkg::cmd_t op_code,
	output logic op_to_eeprom,
	output logic op_keep_eeprom,
	output logic [15:0] op_address,
	output logic [15:0] op_fuse_value,
	output logic boot_area_blank,
	output logic app_code_write_guard,
	output logic eeprom_ready_irq,
	output logic ctrl_asleep,
	output logic clock_hold,
	output logic wake_req,
	output logic buffer_reset
);
	import nvm_pkg::*;

	typedef struct packed {
		cmd_t cmd;
		logic app_guard;
		logic boot_lock;
		logic boot_active;
		logic fault;
		logic irq_en;
		logic ready_flag;
		logic [15:0] fuse_value;
		logic [15:0] address;
		logic [7:0] rdata;
		logic op_start;
		cmd_t op_code;
		logic op_ee;
		logic op_keep;
		logic irq;
		sleep_state_t slp;
		logic asleep;
		logic hold;
		logic wake;
		logic bclr;
	} ctrl_state_t;

	ctrl_state_t s_reg;
	ctrl_state_t s_next;
	nvm_busy_if busy_bus ();

	nvm_busy_tracker u_busy (
		.mclk(mclk),
		.srst(srst),
		.flash_busy_in(flash_busy_in),
		.eeprom_busy_in(eeprom_busy_in),
		.bus(busy_bus.tracker)
	);

	function automatic logic in_eeprom(input logic [15:0] a);
		in_eeprom = (a >= EE_FIRST) && (a <= EE_LAST);
	endfunction

	function automatic logic in_boot(input logic [15:0] a);
		in_boot = (a <= BOOT_LAST);
	endfunction

	function automatic logic in_app(input logic [15:0] a);
		in_app = (a > BOOT_LAST) && (a <= APP_LAST);
	endfunction

	// ==================================================
	// decode helpers
	logic cmd_write;
	logic cmd_taken;
	logic write_busy;
	logic page_cmd;
	logic page_bad;
	cmd_t new_cmd;

	always_comb
	begin
		new_cmd = cmd_t'(reg_wdata[CMD_MSB:CMD_LSB]);
		cmd_write = reg_wr && (reg_addr == OFS_COMMAND);
		// registered busy lags a launch by two edges; launch pulse and raw levels bridge it
		write_busy = busy_bus.write_active || flash_busy_in || eeprom_busy_in || s_reg.op_start;
		// busy arrays refuse a second command; fuse program from the cpu never lands
		cmd_taken = cmd_write && self_program_key_window
			&& !write_busy
			&& !((new_cmd == CMD_FUSE_PROGRAM) && !access_from_debug);
		page_cmd = (new_cmd == CMD_PAGE_PROGRAM) || (new_cmd == CMD_PAGE_WIPE)
			|| (new_cmd == CMD_WIPE_THEN_PROGRAM);
		// boot is never a cpu target of a page command; guarded app code refuses too
		page_bad = page_cmd && (buf_mixed_sections
			|| (in_boot(s_reg.address) && !access_from_debug)
			|| (in_app(s_reg.address) && s_reg.app_guard));
	end

	// ==================================================
	// next state
	always_comb
	begin
		s_next = s_reg;
		s_next.op_start = 1'b0;
		s_next.wake = 1'b0;
		s_next.bclr = 1'b0;
		s_next.rdata = RST_BYTE;

		// command issue
		if (cmd_taken)
		begin
			s_next.cmd = new_cmd;
			s_next.fault = page_bad;
			if (new_cmd != CMD_NONE && !page_bad)
			begin
				s_next.op_start = 1'b1;
				s_next.op_code = new_cmd;
				s_next.op_ee = in_eeprom(s_reg.address);
				s_next.op_keep = keep_eeprom_on_wipe;
			end
		end

		// lock bits are set-only
		if (reg_wr && reg_addr == OFS_LOCK)
		begin
			if (reg_wdata[LOCK_APP_BIT])
				s_next.app_guard = 1'b1;
			if (reg_wdata[LOCK_BOOT_BIT] && exec_in_boot)
				s_next.boot_lock = 1'b1;
		end
		// lock can only be written inside boot, so any cycle outside means boot was left
		if (s_reg.boot_lock && !exec_in_boot)
			s_next.boot_active = 1'b1;

		if (reg_wr && reg_addr == OFS_IRQ_ENABLE)
			s_next.irq_en = reg_wdata[IRQ_READY_BIT];
		if (reg_wr && reg_addr == OFS_FUSE_LO)
			s_next.fuse_value[7:0] = reg_wdata;
		if (reg_wr && reg_addr == OFS_FUSE_HI)
			s_next.fuse_value[15:8] = reg_wdata;
		if (reg_wr && reg_addr == OFS_ADDR_LO)
			s_next.address[7:0] = reg_wdata;
		if (reg_wr && reg_addr == OFS_ADDR_HI)
			s_next.address[15:8] = reg_wdata;
		if (buf_store)
			s_next.address = buf_store_addr;

		// ready flag: clear by one, but a ready level wins over the clear
		if (reg_wr && reg_addr == OFS_IRQ_FLAG && reg_wdata[IRQ_READY_BIT])
			s_next.ready_flag = 1'b0;
		if (busy_bus.ready_pulse || !busy_bus.eeprom_busy)
			s_next.ready_flag = 1'b1;
		s_next.irq = s_next.irq_en && s_next.ready_flag;

		// register reads
		if (reg_rd)
		begin
			case (reg_addr)
				OFS_COMMAND: s_next.rdata = {5'h00, s_reg.cmd};
				OFS_LOCK: s_next.rdata = {6'h00, s_reg.boot_lock, s_reg.app_guard};
				OFS_STATUS: s_next.rdata = {5'h00, s_reg.fault, busy_bus.eeprom_busy,
					busy_bus.flash_busy};
				OFS_IRQ_ENABLE: s_next.rdata = {7'h00, s_reg.irq_en};
				OFS_IRQ_FLAG: s_next.rdata = {7'h00, s_reg.ready_flag};
				OFS_FUSE_LO: s_next.rdata = s_reg.fuse_value[7:0];
				OFS_FUSE_HI: s_next.rdata = s_reg.fuse_value[15:8];
				OFS_ADDR_LO: s_next.rdata = s_reg.address[7:0];
				OFS_ADDR_HI: s_next.rdata = s_reg.address[15:8];
				default: s_next.rdata = RST_BYTE;
			endcase
		end

		// sleep handling
		case (s_reg.slp)
			SLP_RUN:
			begin
				if (sleep_req)
				begin
					if (write_busy)
						s_next.slp = SLP_HOLD;
					else
						s_next.slp = SLP_ASLEEP;
				end
			end
			SLP_HOLD:
			begin
				if (!sleep_req)
				begin
					s_next.slp = SLP_WAKE;
					s_next.bclr = 1'b1;
				end
				else if (!write_busy)
					s_next.slp = SLP_ASLEEP;
			end
			SLP_ASLEEP:
			begin
				if (!sleep_req)
				begin
					s_next.slp = SLP_WAKE;
					s_next.bclr = 1'b1;
				end
				else if (sleep_mode == MODE_IDLE && s_reg.irq)
					s_next.wake = 1'b1;
			end
			SLP_WAKE:
				s_next.slp = SLP_RUN;
			default:
				s_next.slp = SLP_RUN;
		endcase
		s_next.asleep = (s_next.slp == SLP_ASLEEP);
		s_next.hold = (s_next.slp == SLP_HOLD);
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			s_reg <= '0;
			s_reg.slp <= SLP_RUN;
			s_reg.cmd <= CMD_NONE;
			s_reg.op_code <= CMD_NONE;
		end
		else
			s_reg <= s_next;
	end

	// ==================================================
	// outputs
	assign reg_rdata = s_reg.rdata;
	assign op_start = s_reg.op_start;
	assign op_code = s_reg.op_code;
	assign op_to_eeprom = s_reg.op_ee;
	assign op_keep_eeprom = s_reg.op_keep;
	assign op_address = s_reg.address;
	assign op_fuse_value = s_reg.fuse_value;
	assign boot_area_blank = s_reg.boot_active;
	assign app_code_write_guard = s_reg.app_guard;
	assign eeprom_ready_irq = s_reg.irq;
	assign ctrl_asleep = s_reg.asleep;
	assign clock_hold = s_reg.hold;
	assign wake_req = s_reg.wake;
	assign buffer_reset = s_reg.bclr;

	// ==================================================
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	property p_irq_needs_flag;
		eeprom_ready_irq |-> $past(s_next.irq_en) && s_reg.ready_flag && s_reg.irq_en;
	endproperty
	a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("irq without flag");

	property p_locked_cmd;
		(cmd_write && !self_program_key_window) |=> $stable(s_reg.cmd) && !op_start;
	endproperty
	a_locked_cmd: assert property (p_locked_cmd) else $error("unkeyed write took");

	property p_fuse_debug_only;
		(op_start && op_code == CMD_FUSE_PROGRAM) |-> $past(access_from_debug);
	endproperty
	a_fuse_debug_only: assert property (p_fuse_debug_only) else $error("cpu fuse program");

	property p_guard_sticky;
		app_code_write_guard |=> app_code_write_guard [*3];
	endproperty
	a_guard_sticky: assert property (p_guard_sticky) else $error("guard cleared");

	property p_boot_after_leave;
		$rose(boot_area_blank) |-> !$past(exec_in_boot) && $past(s_reg.boot_lock);
	endproperty
	a_boot_after_leave: assert property (p_boot_after_leave) else $error("boot lock early");

	property p_hold_busy;
		(s_reg.slp == SLP_RUN && sleep_req && write_busy) |=> clock_hold;
	endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("clock not held");

	property p_sleep_idle;
		(s_reg.slp == SLP_RUN && sleep_req && !write_busy) |=> ctrl_asleep;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("no sleep");

	property p_wake_idle_only;
		wake_req |-> $past(sleep_mode) == MODE_IDLE && $past(eeprom_ready_irq);
	endproperty
	a_wake_idle_only: assert property (p_wake_idle_only) else $error("deep wake");

	sequence s_leave_sleep;
		(ctrl_asleep && sleep_req) ##1 !sleep_req;
	endsequence

	property p_clear_on_wake;
		s_leave_sleep |=> buffer_reset ##1 !ctrl_asleep;
	endproperty
	a_clear_on_wake: assert property (p_clear_on_wake) else $error("buffer kept");

	property p_fault_mixed;
		(cmd_taken && page_cmd && buf_mixed_sections) |=> s_reg.fault && !op_start;
	endproperty
	a_fault_mixed: assert property (p_fault_mixed) else $error("fault missed");

	property p_ready_flag_set;
		busy_bus.ready_pulse |=> s_reg.ready_flag;
	endproperty
	a_ready_flag_set: assert property (p_ready_flag_set) else $error("flag not set");

	property p_cmd_launch;
		(cmd_taken && new_cmd != CMD_NONE && !page_bad) |=> op_start && op_code == $past(new_cmd);
	endproperty
	a_cmd_launch: assert property (p_cmd_launch) else $error("command not launched");

	property p_flag_clear;
		(reg_wr && reg_addr == OFS_IRQ_FLAG && reg_wdata[IRQ_READY_BIT] && busy_bus.eeprom_busy
			&& !busy_bus.ready_pulse) |=> !s_reg.ready_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_boot_lock_refused;
		(reg_wr && reg_addr == OFS_LOCK && !exec_in_boot && !s_reg.boot_lock) |=> !s_reg.boot_lock;
	endproperty
	a_boot_lock_refused: assert property (p_boot_lock_refused) else $error("boot lock outside");

	property p_irq_idle;
		(s_reg.irq_en && !busy_bus.eeprom_busy && !(reg_wr && reg_addr == OFS_IRQ_ENABLE))
			|=> eeprom_ready_irq;
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("no idle irq");
endmodule

// file: tb/array_model.sv
// stand-in for the flash and eeprom arrays: busy for a while after each launch
`timescale 1ns/100ps
module array_model #(
	parameter int BUSY_CYCLES = 20
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic op_start,
	input wire nvm_pkg::cmd_t op_code,
	input wire logic op_to_eeprom,
	output logic flash_busy_in,
	output logic eeprom_busy_in
);
	import nvm_pkg::*;
	// ====================
	// busy timer
	int cnt_reg;
	logic ee_reg;
	logic fl_reg;
	always @(posedge mclk)
	begin
		if (srst)
		begin
			cnt_reg <= 0;
			ee_reg <= 1'b0;
			fl_reg <= 1'b0;
		end
		else if (op_start)
		begin
			// the array owning the target goes busy, eeprom wipe always hits eeprom
			cnt_reg <= BUSY_CYCLES;
			ee_reg <= op_to_eeprom || (op_code == CMD_EEPROM_WIPE);
			fl_reg <= !(op_to_eeprom || (op_code == CMD_EEPROM_WIPE));
		end
		else if (cnt_reg > 1)
			cnt_reg <= cnt_reg - 1;
		else
		begin
			cnt_reg <= 0;
			ee_reg <= 1'b0;
			fl_reg <= 1'b0;
		end
	end
	assign eeprom_busy_in = ee_reg;
	assign flash_busy_in = fl_reg;
endmodule

// file: tb/testbench.sv
// self-checking bench for the nonvolatile command controller
`timescale 1ns/100ps
module testbench;
	import nvm_pkg::*;
	logic mclk, srst, reg_wr, reg_rd, self_program_key_window, access_from_debug;
	logic exec_in_boot, buf_store, buf_mixed_sections, keep_eeprom_on_wipe, sleep_req;
	logic flash_busy_in, eeprom_busy_in, op_start, op_to_eeprom, op_keep_eeprom;
	logic boot_area_blank, app_code_write_guard, eeprom_ready_irq, ctrl_asleep;
	logic clock_hold, wake_req, buffer_reset;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [15:0] buf_store_addr, op_address, op_fuse_value;
	sleep_mode_t sleep_mode;
	cmd_t op_code;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	nvm_command_controller nvm_command_controller_i (.mclk, .srst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .self_program_key_window, .access_from_debug,
		.exec_in_boot, .buf_store, .buf_store_addr, .buf_mixed_sections,
		.keep_eeprom_on_wipe, .flash_busy_in, .eeprom_busy_in, .sleep_req, .sleep_mode,
		.op_start, .op_code, .op_to_eeprom, .op_keep_eeprom, .op_address, .op_fuse_value,
		.boot_area_blank, .app_code_write_guard, .eeprom_ready_irq, .ctrl_asleep,
		.clock_hold, .wake_req, .buffer_reset);
	array_model array_model_i (.mclk, .srst, .op_start, .op_code, .op_to_eeprom,
		.flash_busy_in, .eeprom_busy_in);
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// ====================
	// tasks
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// an idle edge first, so a strobe is never lowered and raised in one step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		step(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
	endtask
	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		step(1);
		reg_addr = a;
		reg_rd = 1'b1;
		step(1);
		reg_rd = 1'b0;
		chk(what, reg_rdata, exp);
	endtask
	task automatic cmd(input logic [2:0] c, input logic exp_start);
		wr(OFS_COMMAND, {5'h00, c});
		chk("op_start", op_start, exp_start);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		step(1);
		while ((flash_busy_in || eeprom_busy_in) && n < 100)
		begin
			step(1);
			n++;
		end
		// busy is registered inside, flag and irq follow it
		step(4);
	endtask
	task automatic sleep_try(input sleep_mode_t m, input logic exp_wake);
		int w;
		int b;
		w = 0;
		b = 0;
		sleep_mode = m;
		sleep_req = 1'b1;
		repeat (6)
		begin
			step(1);
			if (wake_req === 1'b1)
				w++;
		end
		chk("asleep", ctrl_asleep, 1'b1);
		chk("wake seen", w != 0, exp_wake);
		sleep_req = 1'b0;
		repeat (4)
		begin
			step(1);
			if (buffer_reset === 1'b1)
				b++;
		end
		chk("buffer reset pulses", b[15:0], 16'h0001);
	endtask
	// ====================
	// main sequence
	initial
	begin
		srst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		self_program_key_window = 1'b0;
		access_from_debug = 1'b0;
		exec_in_boot = 1'b0;
		buf_store = 1'b0;
		buf_store_addr = 16'h0000;
		buf_mixed_sections = 1'b0;
		keep_eeprom_on_wipe = 1'b1;
		sleep_req = 1'b0;
		sleep_mode = MODE_IDLE;
		step(12);
		srst = 1'b0;
		rchk("command reset", OFS_COMMAND, 8'h00);
		rchk("lock reset", OFS_LOCK, 8'h00);
		rchk("status reset", OFS_STATUS, 8'h00);
		rchk("ready flag idle", OFS_IRQ_FLAG, 8'h01);
		rchk("unmapped", 4'h5, 8'h00);
		cmd(3'h1, 1'b0);
		rchk("command locked", OFS_COMMAND, 8'h00);
		wr(OFS_ADDR_LO, 8'h00);
		wr(OFS_ADDR_HI, 8'h14);
		rchk("address high", OFS_ADDR_HI, 8'h14);
		self_program_key_window = 1'b1;
		for (int c = 1; c < 7; c++)
		begin
			keep_eeprom_on_wipe = (c != 5);
			cmd(c[2:0], 1'b1);
			chk("op_code", op_code, c[15:0]);
			chk("keep copy", op_keep_eeprom, c != 5);
			if (c < 4)
				chk("to eeprom", op_to_eeprom, 1'b1);
			rchk("command readback", OFS_COMMAND, c[7:0]);
			if (c != 4 && c != 5)
				rchk("eeprom busy", OFS_STATUS, 8'h02);
			if (c == 1)
			begin
				wr(OFS_IRQ_FLAG, 8'h00);
				rchk("flag kept", OFS_IRQ_FLAG, 8'h01);
				wr(OFS_IRQ_FLAG, 8'h01);
				rchk("flag cleared", OFS_IRQ_FLAG, 8'h00);
				wr(OFS_IRQ_ENABLE, 8'h01);
				step(1);
				chk("irq while busy", eeprom_ready_irq, 1'b0);
				wait_idle();
				chk("irq on ready", eeprom_ready_irq, 1'b1);
				rchk("flag on ready", OFS_IRQ_FLAG, 8'h01);
				wr(OFS_IRQ_ENABLE, 8'h00);
				step(1);
				chk("irq disabled", eeprom_ready_irq, 1'b0);
			end
			wait_idle();
		end
		cmd(3'h7, 1'b0);
		wr(OFS_FUSE_LO, 8'hA5);
		wr(OFS_FUSE_HI, 8'h5A);
		wr(OFS_ADDR_LO, 8'h05);
		wr(OFS_ADDR_HI, 8'h00);
		access_from_debug = 1'b1;
		cmd(3'h7, 1'b1);
		chk("fuse value", op_fuse_value, 16'h5AA5);
		chk("fuse address", op_address, 16'h0005);
		access_from_debug = 1'b0;
		wait_idle();
		wr(OFS_IRQ_ENABLE, 8'h01);
		step(1);
		chk("irq idle", eeprom_ready_irq, 1'b1);
		sleep_try(MODE_IDLE, 1'b1);
		sleep_try(MODE_STANDBY, 1'b0);
		sleep_try(MODE_POWER_DOWN, 1'b0);
		wr(OFS_IRQ_ENABLE, 8'h00);
		cmd(3'h6, 1'b1);
		sleep_mode = MODE_POWER_DOWN;
		sleep_req = 1'b1;
		step(3);
		chk("hold clock", clock_hold, 1'b1);
		chk("not asleep", ctrl_asleep, 1'b0);
		wait_idle();
		chk("asleep after write", ctrl_asleep, 1'b1);
		sleep_req = 1'b0;
		step(3);
		buf_mixed_sections = 1'b1;
		wr(OFS_ADDR_HI, 8'h14);
		cmd(3'h1, 1'b0);
		rchk("fault mixed", OFS_STATUS, 8'h04);
		buf_mixed_sections = 1'b0;
		cmd(3'h0, 1'b0);
		rchk("fault cleared", OFS_STATUS, 8'h00);
		wr(OFS_ADDR_HI, 8'h01);
		cmd(3'h2, 1'b0);
		rchk("fault boot", OFS_STATUS, 8'h04);
		wr(OFS_LOCK, 8'h01);
		chk("guard", app_code_write_guard, 1'b1);
		wr(OFS_LOCK, 8'h00);
		rchk("guard sticks", OFS_LOCK, 8'h01);
		wr(OFS_ADDR_HI, 8'h08);
		cmd(3'h1, 1'b0);
		wr(OFS_LOCK, 8'h03);
		rchk("boot lock refused", OFS_LOCK, 8'h01);
		exec_in_boot = 1'b1;
		wr(OFS_LOCK, 8'h02);
		rchk("boot lock set", OFS_LOCK, 8'h03);
		step(2);
		chk("blank in boot", boot_area_blank, 1'b0);
		exec_in_boot = 1'b0;
		step(2);
		chk("blank after leave", boot_area_blank, 1'b1);
		buf_store_addr = 16'h1234;
		buf_store = 1'b1;
		step(1);
		buf_store = 1'b0;
		rchk("stored address", OFS_ADDR_LO, 8'h34);
		srst = 1'b1;
		step(2);
		srst = 1'b0;
		rchk("locks after reset", OFS_LOCK, 8'h00);
		summarize();
	end
endmodule
